/* File: design/tieps_consts.svh */
// register offsets, field positions and reset values of the trigger-edge block
`ifndef TIEPS_CONSTS_SVH
`define TIEPS_CONSTS_SVH
`define TIEPS_CH0_CTRL_OFS   8'h00
`define TIEPS_CH1_CTRL_OFS   8'h04
`define TIEPS_STATUS_OFS     8'h08
`define TIEPS_CH0_COUNT_OFS  8'h0C
`define TIEPS_CH1_COUNT_OFS  8'h10
`define TIEPS_CTRL_RUN       0
`define TIEPS_CTRL_CLK_LO    1
`define TIEPS_CTRL_CLK_HI    2
`define TIEPS_CTRL_E1_LO     3
`define TIEPS_CTRL_E1_HI     4
`define TIEPS_CTRL_E2_LO     5
`define TIEPS_CTRL_E2_HI     6
`define TIEPS_CTRL_PIN_OUT   7
`define TIEPS_CTRL_CLR_START 8
`define TIEPS_CTRL_WIDTH     9
`define TIEPS_CTRL_RESET     9'h000
`define TIEPS_ST_EDGE_A      0
`define TIEPS_ST_EDGE_B1     1
`define TIEPS_ST_EDGE_B2     2
`define TIEPS_ST_CONFL_0     3
`define TIEPS_ST_CONFL_1     4
`define TIEPS_ST_BLOCKED     5
`define TIEPS_ST_WIDTH       6
`define TIEPS_ST_STICKY      6'h07
`define TIEPS_COUNT_MAX      16'hFFFF
`define TIEPS_DIV_SLOW_MASK  3'h7
`endif

/* File: design/tieps_pkg.sv */
// types shared by the trigger-edge block
package tieps_pkg;
  // count clock source of a channel
  typedef enum logic [1:0] {
    TIEPS_CLK_DIV2 = 2'h0,
    TIEPS_CLK_DIV8 = 2'h1,
    TIEPS_CLK_EXT  = 2'h2,
    TIEPS_CLK_OSC  = 2'h3
  } tieps_clk_sel_t;
  // valid-edge selection: bit 1 rising, bit 0 falling
  typedef enum logic [1:0] {
    TIEPS_EDGE_NONE = 2'h0,
    TIEPS_EDGE_FALL = 2'h1,
    TIEPS_EDGE_RISE = 2'h2,
    TIEPS_EDGE_BOTH = 2'h3
  } tieps_edge_sel_t;
endpackage : tieps_pkg

/* File: design/tieps_edge_if.sv */
// carrier between the block top and one trigger-edge detector
`timescale 1ns/1ns
`default_nettype none
interface tieps_edge_if;
  logic       pin;
  logic       tick;
  logic       en;
  logic [1:0] sel;
  logic       rise;
  logic       fall;
  logic       lvl;
  modport det  (input pin, input tick, input en, input sel, output rise, output fall, output lvl);
  modport user (output pin, output tick, output en, output sel, input rise, input fall, input lvl);
endinterface : tieps_edge_if
`default_nettype wire

/* File: design/tieps_edge_det.sv */
// noise-filtered valid-edge detector for one trigger input
`timescale 1ns/1ns
`default_nettype none
module tieps_edge_det
  import tieps_pkg::*;
(
  input  wire logic    hclk,
  input  wire logic    hresetn,
  tieps_edge_if.det    e
);
  logic samp_ff;
  logic lvl_ff;
  logic prev_ff;
  logic seen_run_ff;
  wire  stable  = e.tick & (e.pin == samp_ff);
  wire  track   = e.en | seen_run_ff;

  //////////////////////////////////////////////////////////////////////////////
  // sample on oscillator tick, accept level after two equal samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_ff <= 1'b0;
      lvl_ff  <= 1'b0;
    end else begin
      if (e.tick) samp_ff <= e.pin;
      if (stable) lvl_ff <= e.pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge history: stays low from reset until the first enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff     <= 1'b0;
      seen_run_ff <= 1'b0;
    end else begin
      seen_run_ff <= seen_run_ff | e.en;
      if (track) prev_ff <= lvl_ff;
    end
  end

  // compare successive filtered levels, gated by the selected polarity
  assign e.rise = e.en & e.sel[1] & lvl_ff & ~prev_ff;
  assign e.fall = e.en & e.sel[0] & ~lvl_ff & prev_ff;
  assign e.lvl  = lvl_ff;
endmodule : tieps_edge_det
`default_nettype wire

/* File: design/tieps_top.sv */
// two-channel timer trigger-edge and pin-share block with an AHB-Lite register slave
//
// Summary of operation
// - While channel 0's second trigger edge is in use, port pin a is not its timer output, and vice versa.
// - While channel 1's second trigger edge is in use, port pin b is not its timer output, and vice versa.
// - A trigger input high since reset gives one rising edge when the channel is first enabled.
// - Re-enabling a stopped channel with its trigger input high gives no rising edge.
// - Trigger inputs are sampled by the oscillator tick, so external counting halts on oscillator CPU clock.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tieps_consts.svh"
module tieps_top
  import tieps_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        osc_sample_tick,
  input  wire logic        cpu_on_int_osc,
  input  wire logic        ch1_first_trigger_in,
  input  wire logic        port_pin_a_i,
  output logic             port_pin_a_o,
  output logic             port_pin_a_oe,
  input  wire logic        port_pin_b_i,
  output logic             port_pin_b_o,
  output logic             port_pin_b_oe,
  output logic             ch0_timer_out,
  output logic             ch1_timer_out
);
  // two timer channels
  localparam int NCH = 2;

  // state registers
  logic [`TIEPS_CTRL_WIDTH-1:0] ctrl_ff [NCH];
  logic [15:0]                  cnt_ff  [NCH];
  logic [NCH-1:0]               tout_ff;
  logic [`TIEPS_ST_WIDTH-1:0]   st_ff;
  logic [2:0]                   div_ff;
  logic [31:0]                  rdata_ff;
  logic                         wr_pend_ff;
  logic [7:0]                   wr_addr_ff;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // count tick for a channel from its clock selection
  function automatic logic cnt_tick(input logic [1:0] mode, input logic t2,
                                    input logic t8, input logic ext, input logic blk);
    case (mode)
      TIEPS_CLK_DIV2: cnt_tick = t2;
      TIEPS_CLK_DIV8: cnt_tick = t8;
      TIEPS_CLK_EXT:  cnt_tick = ext & ~blk;
      default:        cnt_tick = 1'b0;
    endcase
  endfunction : cnt_tick

  // read view of a control register
  function automatic logic [31:0] ctrl_word(input logic [`TIEPS_CTRL_WIDTH-1:0] c);
    ctrl_word = {{(32-`TIEPS_CTRL_WIDTH){1'b0}}, c};
  endfunction : ctrl_word

  // read view of a counter
  function automatic logic [31:0] cnt_word(input logic [15:0] c);
    cnt_word = {16'h0000, c};
  endfunction : cnt_word

  // word select of a register offset, low two address bits ignored
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a[7:2] == ofs[7:2]);
  endfunction : reg_hit

  // any enabled edge of one detector
  function automatic logic edge_any(input logic r, input logic f);
    edge_any = r | f;
  endfunction : edge_any

  // write merge: clock field held while the channel runs
  function automatic logic [`TIEPS_CTRL_WIDTH-1:0] ctrl_merge(
    input logic                         running,
    input logic [`TIEPS_CTRL_WIDTH-1:0] old_val,
    input logic [`TIEPS_CTRL_WIDTH-1:0] new_val
  );
    logic [`TIEPS_CTRL_WIDTH-1:0] m;
    logic [1:0]                   keep;
    m    = new_val;
    keep = old_val[`TIEPS_CTRL_CLK_HI:`TIEPS_CTRL_CLK_LO];
    if (running) m[`TIEPS_CTRL_CLK_HI:`TIEPS_CTRL_CLK_LO] = keep;
    ctrl_merge = m;
  endfunction : ctrl_merge

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire       addr_ph  = hsel & htrans[1] & hready;
  wire       rd_req   = addr_ph & ~hwrite;
  wire       wr_req   = addr_ph & hwrite;
  wire       wr_ch0   = wr_pend_ff & reg_hit(wr_addr_ff, `TIEPS_CH0_CTRL_OFS);
  wire       wr_ch1   = wr_pend_ff & reg_hit(wr_addr_ff, `TIEPS_CH1_CTRL_OFS);
  wire       wr_st    = wr_pend_ff & reg_hit(wr_addr_ff, `TIEPS_STATUS_OFS);
  wire [7:0] rd_addr  = {haddr[7:2], 2'b00};

  //////////////////////////////////////////////////////////////////////////////
  // per-channel control fields
  wire [1:0] clk_sel  [NCH];
  wire [1:0] e1_sel   [NCH];
  wire [1:0] e2_raw   [NCH];
  wire [1:0] e2_sel   [NCH];
  wire       run      [NCH];
  wire       pin_out  [NCH];
  wire       clr_st   [NCH];
  wire       blocked  [NCH];
  wire       conflict [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_fld
      assign run[g]      = ctrl_ff[g][`TIEPS_CTRL_RUN];
      assign clk_sel[g]  = ctrl_ff[g][`TIEPS_CTRL_CLK_HI:`TIEPS_CTRL_CLK_LO];
      assign e1_sel[g]   = ctrl_ff[g][`TIEPS_CTRL_E1_HI:`TIEPS_CTRL_E1_LO];
      assign e2_raw[g]   = ctrl_ff[g][`TIEPS_CTRL_E2_HI:`TIEPS_CTRL_E2_LO];
      assign pin_out[g]  = ctrl_ff[g][`TIEPS_CTRL_PIN_OUT];
      assign clr_st[g]   = ctrl_ff[g][`TIEPS_CTRL_CLR_START];
      // timer output on the pin wins; its edge is then left unused
      assign e2_sel[g]   = pin_out[g] ? TIEPS_EDGE_NONE : e2_raw[g];
      assign conflict[g] = pin_out[g] & (e2_raw[g] != TIEPS_EDGE_NONE);
      assign blocked[g]  = cpu_on_int_osc & (clk_sel[g] == TIEPS_CLK_EXT);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // edge detectors: ch0 second, ch1 first, ch1 second
  tieps_edge_if ea_if ();
  tieps_edge_if eb1_if ();
  tieps_edge_if eb2_if ();

  // channel 0 second trigger, shared with pin a
  assign ea_if.pin   = port_pin_a_i;
  assign ea_if.tick  = osc_sample_tick;
  assign ea_if.en    = run[0];
  assign ea_if.sel   = e2_sel[0];

  // channel 1 first trigger
  assign eb1_if.pin  = ch1_first_trigger_in;
  assign eb1_if.tick = osc_sample_tick;
  assign eb1_if.en   = run[1];
  assign eb1_if.sel  = e1_sel[1];

  // channel 1 second trigger, shared with pin b
  assign eb2_if.pin  = port_pin_b_i;
  assign eb2_if.tick = osc_sample_tick;
  assign eb2_if.en   = run[1];
  assign eb2_if.sel  = e2_sel[1];

  tieps_edge_det u_edge_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .e       (ea_if.det)
  );
  tieps_edge_det u_edge_b1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .e       (eb1_if.det)
  );
  tieps_edge_det u_edge_b2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .e       (eb2_if.det)
  );

  // valid edge seen by each detector
  wire edge_a  = edge_any(ea_if.rise, ea_if.fall);
  wire edge_b1 = edge_any(eb1_if.rise, eb1_if.fall);
  wire edge_b2 = edge_any(eb2_if.rise, eb2_if.fall);

  //////////////////////////////////////////////////////////////////////////////
  // count ticks and clear sources
  wire tick2 = div_ff[0];
  wire tick8 = (div_ff == `TIEPS_DIV_SLOW_MASK);
  wire ext_edge [NCH];
  wire clr_edge [NCH];
  wire cnt_en   [NCH];

  assign ext_edge[0] = 1'b0;  // channel 0 has no first trigger input
  assign ext_edge[1] = edge_b1;
  assign clr_edge[0] = 1'b0;
  // same edge as count clock and clear source is not honoured
  assign clr_edge[1] = clr_st[1] & edge_b1 & (clk_sel[1] != TIEPS_CLK_EXT);

  // per-channel count enable
  generate
    for (g = 0; g < NCH; g++) begin : g_tick
      assign cnt_en[g] = run[g] & cnt_tick(clk_sel[g], tick2, tick8, ext_edge[g], blocked[g]);
    end
  endgenerate

  // free running prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_ff <= 3'h0;
    else          div_ff <= div_ff + 3'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // counters and timer outputs, output toggles on overflow
  generate
    for (g = 0; g < NCH; g++) begin : g_cnt
      wire ovf = cnt_en[g] & (cnt_ff[g] == `TIEPS_COUNT_MAX);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_ff[g]  <= 16'h0000;
          tout_ff[g] <= 1'b0;
        end else begin
          if (clr_edge[g])    cnt_ff[g] <= 16'h0000;
          else if (cnt_en[g]) cnt_ff[g] <= cnt_ff[g] + 16'h0001;
          if (ovf)            tout_ff[g] <= ~tout_ff[g];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // control registers; clock field frozen while the channel runs
  wire [`TIEPS_CTRL_WIDTH-1:0] wdat = hwdata[`TIEPS_CTRL_WIDTH-1:0];
  wire [`TIEPS_CTRL_WIDTH-1:0] nxt_ctrl0 = ctrl_merge(run[0], ctrl_ff[0], wdat);
  wire [`TIEPS_CTRL_WIDTH-1:0] nxt_ctrl1 = ctrl_merge(run[1], ctrl_ff[1], wdat);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff[0] <= `TIEPS_CTRL_RESET;
      ctrl_ff[1] <= `TIEPS_CTRL_RESET;
    end else begin
      if (wr_ch0) ctrl_ff[0] <= nxt_ctrl0;
      if (wr_ch1) ctrl_ff[1] <= nxt_ctrl1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status: sticky edge flags (write one to clear, set wins), live flags
  wire [`TIEPS_ST_WIDTH-1:0] st_set;
  assign st_set[`TIEPS_ST_EDGE_A]  = edge_a;
  assign st_set[`TIEPS_ST_EDGE_B1] = edge_b1;
  assign st_set[`TIEPS_ST_EDGE_B2] = edge_b2;
  assign st_set[`TIEPS_ST_CONFL_0] = conflict[0];
  assign st_set[`TIEPS_ST_CONFL_1] = conflict[1];
  assign st_set[`TIEPS_ST_BLOCKED] = blocked[0] | blocked[1];
  wire [`TIEPS_ST_WIDTH-1:0] st_clr  = wr_st ? hwdata[`TIEPS_ST_WIDTH-1:0] : 6'h00;
  wire [`TIEPS_ST_WIDTH-1:0] nxt_st  = (((st_ff & ~st_clr) | st_set) & `TIEPS_ST_STICKY)
                                       | (st_set & ~`TIEPS_ST_STICKY);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_ff <= 6'h00;
    else          st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: write taken in data phase, read data registered at address phase
  wire [31:0] rd_mux =
    reg_hit(rd_addr, `TIEPS_CH0_CTRL_OFS)  ? ctrl_word(ctrl_ff[0]) :
    reg_hit(rd_addr, `TIEPS_CH1_CTRL_OFS)  ? ctrl_word(ctrl_ff[1]) :
    reg_hit(rd_addr, `TIEPS_STATUS_OFS)    ? {26'h000_0000, st_ff} :
    reg_hit(rd_addr, `TIEPS_CH0_COUNT_OFS) ? cnt_word(cnt_ff[0]) :
    reg_hit(rd_addr, `TIEPS_CH1_COUNT_OFS) ? cnt_word(cnt_ff[1]) : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= wr_req;
      if (wr_req) wr_addr_ff <= rd_addr;
      if (rd_req) rdata_ff <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout     = 1'b1;   // zero wait states
  assign hresp         = 1'b0;   // always okay
  assign hrdata        = rdata_ff;
  assign port_pin_a_o  = tout_ff[0];
  assign port_pin_a_oe = pin_out[0];
  assign port_pin_b_o  = tout_ff[1];
  assign port_pin_b_oe = pin_out[1];
  assign ch0_timer_out = tout_ff[0];
  assign ch1_timer_out = tout_ff[1];

  // inputs and detector levels the block does not need
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[1:0], ea_if.lvl, eb1_if.lvl, eb2_if.lvl};
endmodule : tieps_top
`default_nettype wire

/* File: tb/tieps_properties.sv */
// port-level assertions for the trigger-edge and pin-share block
`timescale 1ns/1ns
`default_nettype none
module tieps_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        port_pin_a_o,
  input wire logic        port_pin_a_oe,
  input wire logic        port_pin_b_o,
  input wire logic        port_pin_b_oe,
  input wire logic        ch0_timer_out,
  input wire logic        ch1_timer_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr0_dp_ff;
  wire  taken = hsel && htrans[1] && hready;
  wire  wr0_ap = taken && hwrite && (haddr[7:2] == 6'h00);
  ////////////////////////////////////////////////////////////////////////////////
  // data phase marker of a write to the channel 0 control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr0_dp_ff <= 1'b0;
    else wr0_dp_ff <= wr0_ap;
  end
  // address phase then its data phase
  sequence s_wr(logic [5:0] w);
    taken && hwrite && (haddr[7:2] == w) ##1 1'b1;
  endsequence
  sequence s_rd(logic [5:0] w);
    taken && !hwrite && (haddr[7:2] == w);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_oe_a_write:
    assert property (s_wr(6'h00) |=> port_pin_a_oe == $past(hwdata[7]))
    else $error("pin a enable not from write");
  a_oe_b_write:
    assert property (s_wr(6'h01) |=> port_pin_b_oe == $past(hwdata[7]))
    else $error("pin b enable not from write");
  a_oe_a_cause:
    assert property ($changed(port_pin_a_oe) |-> $past(wr0_dp_ff))
    else $error("pin a enable moved without write");
  a_pin_a_mirror:
    assert property (port_pin_a_oe |-> port_pin_a_o == ch0_timer_out)
    else $error("pin a not carrying timer out");
  a_pin_b_mirror:
    assert property (port_pin_b_oe |-> port_pin_b_o == ch1_timer_out)
    else $error("pin b not carrying timer out");
  a_status_upper_zero:
    assert property (s_rd(6'h02) |=> hrdata[31:6] == 26'h0)
    else $error("status upper bits set");
  a_unmapped_zero:
    assert property (taken && !hwrite && haddr[7:2] > 6'h04 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold:
    assert property ($changed(hrdata) |-> $past(taken && !hwrite))
    else $error("read data moved without read");
endmodule : tieps_properties
bind tieps_top tieps_properties tieps_properties_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .port_pin_a_o(port_pin_a_o),
  .port_pin_a_oe(port_pin_a_oe), .port_pin_b_o(port_pin_b_o),
  .port_pin_b_oe(port_pin_b_oe), .ch0_timer_out(ch0_timer_out),
  .ch1_timer_out(ch1_timer_out));
`default_nettype wire

/* File: tb/tieps_pin_model.sv */
// far side: trigger pins and the oscillator sample tick
`timescale 1ns/1ns
`default_nettype none
module tieps_pin_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic drv_a,
  input  wire logic drv_b,
  input  wire logic drv_c,
  input  wire logic pin_a_o,
  input  wire logic pin_a_oe,
  input  wire logic pin_b_o,
  input  wire logic pin_b_oe,
  output logic      tick,
  output logic      trig_c,
  output logic      pin_a_i,
  output logic      pin_b_i
);
  logic [1:0] div_ff;
  // oscillator sample tick, one clock in four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_ff <= 2'h0;
    else div_ff <= div_ff + 2'h1;
  end
  assign tick = (div_ff == 2'h0);
  // shared pin level: timer output wins while enabled
  assign pin_a_i = pin_a_oe ? pin_a_o : drv_a;
  assign pin_b_i = pin_b_oe ? pin_b_o : drv_b;
  assign trig_c = drv_c;
endmodule : tieps_pin_model
`default_nettype wire

/* File: tb/tb.sv */
// register-level testbench of the trigger-edge and pin-share block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tieps_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, cpu_on, tick, trig_c;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, v;
  logic        drv_a, drv_b, drv_c, a_i, a_o, a_oe, b_i, b_o, b_oe, t0, t1;
  int          error_cnt, check_count, i;
  tieps_top tieps_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_sample_tick(tick),
    .cpu_on_int_osc(cpu_on), .ch1_first_trigger_in(trig_c), .port_pin_a_i(a_i),
    .port_pin_a_o(a_o), .port_pin_a_oe(a_oe), .port_pin_b_i(b_i), .port_pin_b_o(b_o),
    .port_pin_b_oe(b_oe), .ch0_timer_out(t0), .ch1_timer_out(t1));
  tieps_pin_model tieps_pin_model_i (.hclk(hclk), .hresetn(hresetn), .drv_a(drv_a),
    .drv_b(drv_b), .drv_c(drv_c), .pin_a_o(a_o), .pin_a_oe(a_oe), .pin_b_o(b_o),
    .pin_b_oe(b_oe), .tick(tick), .trig_c(trig_c), .pin_a_i(a_i), .pin_b_i(b_i));
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 hclk = ~hclk;
  task summarize;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // bounded wait for hready at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      summarize;
    end
  endtask : wait_rdy
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy;
    d = hrdata;
  endtask : rd
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdc
  // filter needs two agreeing ticks plus a clock
  task settle;
    repeat (30) @(posedge hclk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hresetn = 0; hsel = 0; haddr = 8'h00; htrans = 2'h0; hwrite = 0;
    hsize = 3'h2; hwdata = 32'h0000_0000; cpu_on = 0; drv_a = 1; drv_b = 0; drv_c = 1;
    error_cnt = 0; check_count = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0041);
    wr(8'h04, 32'h0000_0011);
    settle;
    rdc(8'h08, 32'h0000_0003);
    wr(8'h08, 32'h0000_0007);
    drv_a <= 1'b0;
    settle;
    rdc(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0040);
    drv_a <= 1'b1;
    settle;
    wr(8'h00, 32'h0000_0041);
    settle;
    rdc(8'h08, 32'h0000_0000);
    drv_a <= 1'b0;
    settle;
    drv_a <= 1'b1;
    settle;
    rdc(8'h08, 32'h0000_0001);
    wr(8'h08, 32'h0000_0007);
    // pin used as timer output while its second edge is selected
    for (i = 0; i < 2; i++) begin
      wr(8'(i * 4), 32'h0000_00C1);
      settle;
      chk({31'h0, (i == 0) ? a_oe : b_oe}, 32'h0000_0001);
      rdc(8'h08, (i == 0) ? 32'h0000_0008 : 32'h0000_0018);
    end
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0011);
    wr(8'h04, 32'h0000_0015);
    rdc(8'h04, 32'h0000_0011);
    wr(8'h04, 32'h0000_0010);
    wr(8'h04, 32'h0000_0014);
    rdc(8'h04, 32'h0000_0014);
    // external count clock blocked while the cpu runs on the oscillator
    cpu_on <= 1'b1;
    wr(8'h04, 32'h0000_0015);
    wr(8'h08, 32'h0000_0007);
    rdc(8'h08, 32'h0000_0020);
    rd(8'h10, v);
    drv_c <= 1'b0;
    settle;
    drv_c <= 1'b1;
    settle;
    rdc(8'h10, v);
    cpu_on <= 1'b0;
    drv_c <= 1'b0;
    settle;
    drv_c <= 1'b1;
    settle;
    rdc(8'h10, v + 32'h0000_0001);
    wr(8'h00, 32'h0000_0007);
    rd(8'h0C, v);
    settle;
    rdc(8'h0C, v);
    // falling edge only, on the second trigger of channel 0
    wr(8'h08, 32'h0000_0007);
    wr(8'h00, 32'h0000_0027);
    drv_a <= 1'b0;
    settle;
    rdc(8'h08, 32'h0000_0001);
    // clear on first trigger edge while not counting on that edge
    wr(8'h04, 32'h0000_0014);
    wr(8'h04, 32'h0000_0117);
    drv_c <= 1'b0;
    settle;
    drv_c <= 1'b1;
    settle;
    rdc(8'h10, 32'h0000_0000);
    // no overflow yet: timer outputs and pin levels still low
    chk({28'h000_0000, b_o, a_o, t1, t0}, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0000);
    summarize;
  end
endmodule : tb
`default_nettype wire
